// ---- src/adc_conversion_timing_control.sv ----
// converter control: register port, conversion timer, done flag and interrupt
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module adc_conversion_timing_control #(
   parameter int RES_BITS = adc_ctrl_pkg::RES_W
) (
   input  wire logic                              i_sys_clk,
   input  wire logic                              i_rst_n,
   input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [adc_ctrl_pkg::DATA_W-1:0]   i_wdata,
   input  wire logic                              i_wr,
   input  wire logic                              i_rd,
   input  wire logic [RES_BITS-1:0]               i_sar_result,
   output logic      [adc_ctrl_pkg::DATA_W-1:0]   o_rdata,
   output logic      [2:0]                        o_channel,
   output logic                                   o_comparator_enable,
   output logic                                   o_sample_start,
   output logic                                   o_conversion_done_irq
);
   import adc_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef enum logic [1:0] {IDLE, CONVERT} conv_state_type;

   mode_type            mode,    next_mode;
   logic [2:0]          chan,    next_chan;
   logic [DATA_W-1:0]   pincfg,  next_pincfg;
   logic [RES_BITS-1:0] result,  next_result;
   logic [2:0]          status,  next_status;
   logic [2:0]          mask,    next_mask;
   logic [DATA_W-1:0]   rdata,   next_rdata;
   conv_state_type      state,   next_state;
   logic [CNT_W-1:0]    cnt,     next_cnt;
   logic [CNT_W-1:0]    settle,  next_settle;
   logic                first,   next_first;
   timing_type          timing;
   logic                done_evt;
   logic                err_evt;
   logic                wr_mode;
   logic                wr_chan;
   logic                wr_pin;
   logic                wr_mask;
   logic                wr_status;
   logic [2:0]          set_bits;

   adc_rate_decode u_decode (
      .i_mode   (mode),
      .o_timing (timing)
   );

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   always_comb begin
      wr_mode     = i_wr && (i_addr == OFF_MODE);
      wr_chan     = i_wr && (i_addr == OFF_CHANNEL);
      wr_pin      = i_wr && (i_addr == OFF_PINCFG);
      wr_mask     = i_wr && (i_addr == OFF_MASK);
      next_mode   = wr_mode ? mode_type'(i_wdata) : mode;
      next_chan   = wr_chan ? i_wdata[2:0] : chan;
      next_pincfg = wr_pin ? i_wdata : pincfg;
      next_mask   = wr_mask ? i_wdata[2:0] : mask;
   end

   // rate fields only take effect at the next reload, hence stop before changing them
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         mode   <= mode_type'(RESET_BYTE);
         chan   <= '0;
         pincfg <= PINCFG_RST;
         mask   <= '0;
      end else begin
         mode   <= next_mode;
         chan   <= next_chan;
         pincfg <= next_pincfg;
         mask   <= next_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparator settle timer

   // restarts whenever the comparator is off, saturates once settled
   always_comb begin
      if (!mode.comparator_enable) begin
         next_settle = '0;
      end else if (settle < CNT_W'(SETTLE_CYC)) begin
         next_settle = settle + CNT_W'(1);
      end else begin
         next_settle = settle;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         settle <= '0;
      end else begin
         settle <= next_settle;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencing

   always_comb begin
      next_state  = state;
      next_cnt    = cnt;
      next_result = result;
      next_first  = first;
      done_evt    = 1'b0;
      err_evt     = 1'b0;
      case (state)
         IDLE: begin
            if (mode.conversion_run) begin
               if (!timing.valid) begin
                  err_evt = 1'b1;
               end else begin
                  next_first = !mode.comparator_enable
                               || (settle < CNT_W'(SETTLE_CYC));
                  next_cnt   = timing.total - CNT_W'(1);
                  next_state = CONVERT;
               end
            end
         end
         CONVERT: begin
            if (!mode.conversion_run) begin
               next_state = IDLE;
            end else if (cnt == '0) begin
               next_result = i_sar_result;
               done_evt    = 1'b1;
               next_cnt    = timing.total - CNT_W'(1);
               next_first  = 1'b0;
               if (!timing.valid) begin
                  next_state = IDLE;
               end
            end else begin
               next_cnt = cnt - CNT_W'(1);
            end
         end
         default: next_state = IDLE;
      endcase
      // mode, channel and pin config writes corrupt the result, modelled as cleared unless a result is captured in the same cycle
      if ((wr_mode || wr_chan || wr_pin) && !done_evt) begin
         next_result = '0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         result <= '0;
         state  <= IDLE;
         cnt    <= '0;
         first  <= 1'b0;
      end else begin
         result <= next_result;
         state  <= next_state;
         cnt    <= next_cnt;
         first  <= next_first;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky status flags

   always_comb begin
      set_bits = 3'b000;
      set_bits[STAT_DONE]  = done_evt;
      set_bits[STAT_ERR]   = err_evt;
      set_bits[STAT_FIRST] = done_evt && first;
      // channel write never touches the flags; set wins over clear
      wr_status = i_wr && (i_addr == OFF_STATUS);
      if (wr_status) begin
         next_status = (status & ~i_wdata[2:0]) | set_bits;
      end else begin
         next_status = status | set_bits;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         status <= '0;
      end else begin
         status <= next_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port

   // read data stands one cycle after the strobe only, so an idle bus reads zero
   always_comb begin
      case (i_addr)
         OFF_MODE:    next_rdata = mode;
         OFF_CHANNEL: next_rdata = {5'h00, chan};
         OFF_PINCFG:  next_rdata = pincfg;
         OFF_RES_LO:  next_rdata = result[DATA_W-1:0];
         OFF_RES_HI:  next_rdata = DATA_W'(result >> DATA_W);
         OFF_STATUS:  next_rdata = {5'h00, status};
         OFF_MASK:    next_rdata = {5'h00, mask};
         default:     next_rdata = RESET_BYTE;
      endcase
      if (!i_rd) begin
         next_rdata = RESET_BYTE;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rdata <= RESET_BYTE;
      end else begin
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign o_rdata               = rdata;
   assign o_channel             = chan;
   assign o_comparator_enable   = mode.comparator_enable;
   assign o_sample_start        = (state == IDLE) && (next_state == CONVERT);
   assign o_conversion_done_irq = |(status & mask);
endmodule

// ---- src/adc_ctrl_pkg.sv ----
// constants and types for the converter conversion timing control
package adc_ctrl_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int RES_W  = 10;

   localparam logic [ADDR_W-1:0] OFF_MODE    = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_CHANNEL = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_PINCFG  = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_RES_LO  = 4'h3;
   localparam logic [ADDR_W-1:0] OFF_RES_HI  = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 4'h5;
   localparam logic [ADDR_W-1:0] OFF_MASK    = 4'h6;

   localparam logic [DATA_W-1:0] RESET_BYTE  = 8'h00;
   localparam logic [DATA_W-1:0] PINCFG_RST  = 8'h00;

   localparam int STAT_DONE  = 0;
   localparam int STAT_ERR   = 1;
   localparam int STAT_FIRST = 2;

   // comparator settle time before run is trustworthy
   localparam int  CLK_MHZ       = 100;
   localparam int  SETTLE_US     = 1;
   localparam int  SETTLE_CYC    = SETTLE_US * CLK_MHZ;
   localparam int  CNT_W         = 10;

   // mode register layout, the whole byte of the register bus
   typedef struct packed {
      logic       conversion_run;
      logic       rate_select_bit3;
      logic       rate_select_bit2;
      logic       rate_select_bit1;
      logic       rate_select_bit0;
      logic       low_ref_timing_bit1;
      logic       low_ref_timing_bit0;
      logic       comparator_enable;
   } mode_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_type;

   typedef struct packed {
      logic              valid;
      logic [CNT_W-1:0]  total;
   } timing_type;

   localparam logic [CNT_W-1:0] TOT_352 = 10'h160;
   localparam logic [CNT_W-1:0] TOT_264 = 10'h108;
   localparam logic [CNT_W-1:0] TOT_176 = 10'h0b0;
   localparam logic [CNT_W-1:0] TOT_132 = 10'h084;
   localparam logic [CNT_W-1:0] TOT_88  = 10'h058;
   localparam logic [CNT_W-1:0] TOT_66  = 10'h042;
   localparam logic [CNT_W-1:0] TOT_44  = 10'h02c;
   localparam logic [CNT_W-1:0] TOT_480 = 10'h1e0;
   localparam logic [CNT_W-1:0] TOT_320 = 10'h140;
   localparam logic [CNT_W-1:0] TOT_240 = 10'h0f0;
   localparam logic [CNT_W-1:0] TOT_160 = 10'h0a0;
   localparam logic [CNT_W-1:0] TOT_120 = 10'h078;
   localparam logic [CNT_W-1:0] TOT_80  = 10'h050;
endpackage

// ---- src/adc_rate_decode.sv ----
// conversion time decoder from rate and low-ref timing fields
`timescale 1ns/1ps
module adc_rate_decode (
   input  wire adc_ctrl_pkg::mode_type   i_mode,
   output adc_ctrl_pkg::timing_type      o_timing
);
   import adc_ctrl_pkg::*;

   logic [3:0] rate;
   logic [1:0] lvt;

   always_comb begin
      rate = {i_mode.rate_select_bit3, i_mode.rate_select_bit2,
              i_mode.rate_select_bit1, i_mode.rate_select_bit0};
      lvt  = {i_mode.low_ref_timing_bit1, i_mode.low_ref_timing_bit0};
      o_timing.valid = 1'b1;
      o_timing.total = TOT_44;
      if (lvt == 2'h0) begin
         if (rate[3]) begin
            o_timing.total = TOT_352;
         end else begin
            case (rate[2:0])
               3'h0:    o_timing.total = TOT_264;
               3'h1:    o_timing.total = TOT_176;
               3'h2:    o_timing.total = TOT_132;
               3'h3:    o_timing.total = TOT_88;
               3'h4:    o_timing.total = TOT_66;
               3'h5:    o_timing.total = TOT_44;
               default: o_timing.valid = 1'b0;
            endcase
         end
      end else if (lvt == 2'h1) begin
         case (rate)
            4'h0:    o_timing.total = TOT_480;
            4'h1:    o_timing.total = TOT_320;
            4'h2:    o_timing.total = TOT_240;
            4'h3:    o_timing.total = TOT_160;
            4'h4:    o_timing.total = TOT_120;
            4'h5:    o_timing.total = TOT_80;
            default: o_timing.valid = 1'b0;
         endcase
      end else begin
         o_timing.valid = 1'b0;
      end
   end
endmodule

// ---- test/adc_conversion_timing_control_test.sv ----
// self-checking bench for the converter conversion timing control
`timescale 1ns/1ps
module adc_conversion_timing_control_test;
   import adc_ctrl_pkg::*;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [9:0] sar = 10'h000;
   logic [7:0] rdata;
   logic [2:0] chan;
   logic       cmp, start, irq;
   int         n_errors = 0;
   int         num_checks = 0;
   int         cycles = 0;
   int         t0[6] = '{264, 176, 132, 88, 66, 44};
   int         t1[6] = '{480, 320, 240, 160, 120, 80};
   logic [5:0] bad[4] = '{6'h18, 6'h21, 6'h02, 6'h03};
   adc_conversion_timing_control u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_sar_result(sar), .o_rdata(rdata),
      .o_channel(chan), .o_comparator_enable(cmp), .o_sample_start(start),
      .o_conversion_done_irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string name);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(name, {8'h00, exp}, {8'h00, rdata});
   endtask
   // totals per setting, zero where prohibited
   function automatic int total_of(input logic [3:0] fr, input logic [1:0] lv);
      if (lv == 2'b00 && fr[3]) return 352;
      if (fr > 4'h5 || lv > 2'b01) return 0;
      return (lv == 2'b01) ? t1[fr] : t0[fr];
   endfunction
   task automatic convert(input logic [3:0] fr, input logic [1:0] lv, input logic [7:0] st);
      int         n;
      int         t;
      logic [7:0] c;
      t = total_of(fr, lv);
      n = 0;
      sar <= 10'($urandom);
      wr_reg(OFF_STATUS, 8'h07); // clear before run
      wr_reg(OFF_MODE, {1'b1, fr, lv, 1'b1});
      chk("sample start", 16'h0001, {15'h0000, start});
      chk("comparator enable", 16'h0001, {15'h0000, cmp});
      while (irq !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
      chk("conversion time", 16'h0001, {15'h0000, n >= t && n <= t + 2});
      rd_chk(OFF_RES_LO, sar[7:0], "result low");
      rd_chk(OFF_RES_HI, {6'h00, sar[9:8]}, "result high");
      c = 8'($urandom);
      wr_reg(OFF_CHANNEL, c);
      chk("channel", {13'h0000, c[2:0]}, {13'h0000, chan});
      rd_chk(OFF_STATUS, st, "status after channel write");
      wr_reg(OFF_MASK, 8'h00);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      wr_reg(OFF_MASK, 8'h01);
      chk("irq unmasked", 16'h0001, {15'h0000, irq});
      wr_reg(OFF_MODE, 8'h01); // stop before rate change
      rd_chk(OFF_RES_LO, 8'h00, "result after mode write");
      wr_reg(OFF_STATUS, 8'h07);
      chk("irq cleared", 16'h0000, {15'h0000, irq});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      forever begin
         @(posedge clk);
         cycles++;
         if (cycles > 20000) begin
            n_errors++;
            summarize();
         end
      end
   end
   initial begin
      logic [7:0] p;
      void'($urandom(32'h68a76c43));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 8; a++) rd_chk(4'(a), 8'h00, "reset value");
      p = 8'($urandom);
      wr_reg(OFF_PINCFG, p);
      rd_chk(OFF_PINCFG, p, "pin config");
      wr_reg(4'hf, 8'hff);
      rd_chk(4'hf, 8'h00, "unmapped");
      $display("test registers done");
      wr_reg(OFF_MASK, 8'h01);
      wr_reg(OFF_MODE, 8'h01);
      repeat (120) @(posedge clk);
      for (int i = 0; i < 13; i++) begin
         if (i < 12) convert(4'(i % 6), 2'(i / 6), 8'h01);
         else convert(4'h8 | 4'($urandom), 2'b00, 8'h01);
      end
      $display("test conversion rates done");
      foreach (bad[k]) begin
         wr_reg(OFF_STATUS, 8'h07);
         wr_reg(OFF_MODE, {1'b1, bad[k], 1'b1});
         chk("no start when prohibited", 16'h0000, {15'h0000, start});
         repeat (60) @(posedge clk);
         rd_chk(OFF_STATUS, 8'h02, "prohibited setting");
         wr_reg(OFF_MODE, 8'h01);
      end
      $display("test prohibited settings done");
      wr_reg(OFF_MODE, 8'h00);
      chk("comparator off", 16'h0000, {15'h0000, cmp});
      wr_reg(OFF_STATUS, 8'h07);
      convert(4'h5, 2'b00, 8'h05);
      $display("test early first result done");
      summarize();
   end
endmodule

// ---- test/adc_ctrl_sva.sv ----
// port assertions for the converter conversion timing control
`timescale 1ns/1ps
module adc_ctrl_sva (
   input wire logic                            i_sys_clk,
   input wire logic                            i_rst_n,
   input wire logic [adc_ctrl_pkg::ADDR_W-1:0] i_addr,
   input wire logic [adc_ctrl_pkg::DATA_W-1:0] i_wdata,
   input wire logic                            i_wr,
   input wire logic                            i_rd,
   input wire logic [adc_ctrl_pkg::DATA_W-1:0] o_rdata,
   input wire logic [2:0]                      o_channel,
   input wire logic                            o_comparator_enable,
   input wire logic                            o_sample_start,
   input wire logic                            o_conversion_done_irq
);
   import adc_ctrl_pkg::*;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////////
   read_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (i_rd && i_addr > OFF_MASK |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   channel_read_a: assert property (i_rd && i_addr == OFF_CHANNEL
      |=> o_rdata == {5'h00, $past(o_channel)})
      else $error("channel readback differs from channel output");
   channel_write_a: assert property (i_wr && i_addr == OFF_CHANNEL |=> o_channel == $past(i_wdata[2:0]))
      else $error("channel output did not follow write");
   cmp_follow_a: assert property (i_wr && i_addr == OFF_MODE |=> o_comparator_enable == $past(i_wdata[0]))
      else $error("comparator enable did not follow mode write");
   start_pulse_a: assert property (o_sample_start ##1 !(i_wr && i_addr == OFF_MODE) [*8]
      |=> !o_sample_start)
      else $error("sample start repeated too soon");
   mask_off_a: assert property (i_wr && i_addr == OFF_MASK && i_wdata == 8'h00 |=> !o_conversion_done_irq)
      else $error("interrupt high with mask cleared");
   channel_keep_a: assert property (i_wr && i_addr == OFF_CHANNEL && o_conversion_done_irq |=> o_conversion_done_irq)
      else $error("channel write dropped the done interrupt");
endmodule
bind adc_conversion_timing_control adc_ctrl_sva u_sva (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_channel(o_channel), .o_comparator_enable(o_comparator_enable),
   .o_sample_start(o_sample_start), .o_conversion_done_irq(o_conversion_done_irq));
